// file: design/netf_defines.vh
// constants for the navigation epoch time formatter
`ifndef NETF_DEFINES_VH
`define NETF_DEFINES_VH
`define NETF_CLK_HZ        200000000
`define NETF_TICK_HZ       1000
`define NETF_TICK_DIV      (`NETF_CLK_HZ / `NETF_TICK_HZ)
`define NETF_EPOCH_NOM     16'd1000
`define NETF_EPOCH_SHORT   16'd999
`define NETF_EPOCH_LONG    16'd1001
`define NETF_MS_PER_WEEK   32'd604800000
`define NETF_NS_PER_MS     32'd1000000
`define NETF_ROUND_HALF_NS 32'd5000000
`define NETF_ROUND_STEP_NS 32'd10000000
`define NETF_DEF_LEAP_S    8'h12
`define NETF_DEF_GLO_OFS_S 8'h12
`define NETF_BIAS_STEP_MS  32'sd1
`define NETF_YEAR_BASE     12'h7bc
`define NETF_BASE_WEEK_RST 16'h0000
`endif

// file: design/netf_date_conv.v
// converts a day count since the time origin into year, month and day
`include "netf_defines.vh"
module netf_date_conv
(
   input  wire        i_clk,   // system clock
   input  wire        i_rst_n, // asynchronous reset, active low
   input  wire        i_start, // start one conversion
   input  wire [19:0] i_days,  // days since first day of 1980
   output reg         o_done,  // one-cycle pulse when result ready
   output reg  [11:0] o_year,  // calendar year
   output reg  [3:0]  o_month, // month 1..12
   output reg  [4:0]  o_day    // day of month 1..31
);
   reg        busy_r;
   reg [19:0] rem_r;
   reg [11:0] yr_r;
   reg [3:0]  mo_r;
   reg        phase_r;

   // days in a month, leap years by the four-year rule
   function [4:0] mdays;
      input [11:0] y;
      input [3:0]  m;
      begin
         case (m)
            4'h2: mdays = (y[1:0] == 2'b00) ? 5'd29 : 5'd28;
            4'h4, 4'h6, 4'h9, 4'hb: mdays = 5'd30;
            default: mdays = 5'd31;
         endcase
      end
   endfunction

   wire [8:0] ylen = (yr_r[1:0] == 2'b00) ? 9'd366 : 9'd365;
   wire [4:0] mlen = mdays(yr_r, mo_r);

   // iterative subtraction: one cycle per year, then one per month, far inside one 1 ms tick
   always @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         busy_r  <= 1'b0;
         rem_r   <= 20'h00000;
         yr_r    <= 12'h000;
         mo_r    <= 4'h1;
         phase_r <= 1'b0;
         o_done  <= 1'b0;
         o_year  <= 12'h000;
         o_month <= 4'h1;
         o_day   <= 5'h01;
      end
      else
      begin
         o_done <= 1'b0;
         if (i_start)
         begin
            busy_r  <= 1'b1;
            rem_r   <= i_days;
            yr_r    <= `NETF_YEAR_BASE;
            mo_r    <= 4'h1;
            phase_r <= 1'b0;
         end
         else if (busy_r)
         begin
            if (!phase_r)
            begin
               if (rem_r >= {11'h000, ylen})
               begin
                  rem_r <= rem_r - {11'h000, ylen};
                  yr_r  <= yr_r + 12'h001;
               end
               else
                  phase_r <= 1'b1;
            end
            else if (rem_r >= {15'h0000, mlen})
            begin
               rem_r <= rem_r - {15'h0000, mlen};
               mo_r  <= mo_r + 4'h1;
            end
            else
            begin
               busy_r  <= 1'b0;
               o_done  <= 1'b1;
               o_year  <= yr_r;
               o_month <= mo_r;
               o_day   <= rem_r[4:0] + 5'h01;
            end
         end
      end
   end
endmodule

// file: design/netf_top.v
// navigation epoch scheduler, time base conversion and utc formatter
`include "netf_defines.vh"
module netf_top
(
   input  wire        I_MCLK,          // 200 mhz clock
   input  wire        I_RESETN,        // asynchronous reset, active low
   input  wire        I_SOLN_VALID,    // pulse: solved system time available
   input  wire [31:0] I_SOLN_TOW_MS,   // solved system time of week, ms
   input  wire [19:0] I_SOLN_NS,       // solved sub-ms part, ns
   input  wire        I_SOLN_IS_GLO,   // solved time is glonass based
   input  wire        I_BCAST_VALID,   // pulse: broadcast utc parameters
   input  wire [7:0]  I_BCAST_LEAP,    // broadcast leap seconds
   input  wire        I_AID_VALID,     // pulse: utc_parameter_aiding_msg
   input  wire [7:0]  I_AID_LEAP,      // aiding leap seconds
   input  wire [7:0]  I_GLO_OFS,       // glonass-to-gps offset, s
   input  wire        I_GLO_OFS_OK,    // glonass offset known
   input  wire        I_WEEK_OK,       // week number known
   input  wire [15:0] I_WEEK,          // week number since 1980
   input  wire        I_DATE_CHECK,    // date independently verified
   input  wire        I_TIME_CHECK,    // time independently verified
   input  wire        I_CHECK_AVAIL,   // verification source present
   input  wire        I_OUT_INVALID,   // allow output of invalid times
   input  wire        I_PRIO_MODE,     // priority navigation mode
   input  wire        I_PRIO_GROUP,    // group of this epoch's reports
   input  wire        I_NMEA_LEGACY,   // nmea_legacy_format_setting
   input  wire [2:0]  I_UTC_VARIANT,   // utc_variant_select
   output reg         O_EPOCH,         // pulse: navigation epoch tick
   output reg         O_REPORT,        // pulse: reports for epoch ready
   output reg  [31:0] O_EPOCH_WEEK_TIME_STAMP, // gps time of week, ms
   output reg  [15:0] O_WEEK,          // gps week
   output reg         O_GROUP,         // report group tag
   output reg  [31:0] O_LOCAL_MS,      // local time, ms
   output reg  [31:0] O_CLOCK_BIAS,    // solved minus local, ms, signed
   output reg  [31:0] O_CLOCK_DRIFT,   // bias change per epoch, ms, signed
   output reg  [11:0] O_YEAR,          // utc year
   output reg  [3:0]  O_MONTH,         // utc month
   output reg  [4:0]  O_DAY,           // utc day
   output reg  [4:0]  O_HOUR,          // utc hour
   output reg  [5:0]  O_MIN,           // utc minute
   output reg  [5:0]  O_SEC,           // utc second
   output reg  [31:0] O_NANO,          // signed ns correction
   output reg  [6:0]  O_HUNDREDTHS,    // nmea fractional hundredths
   output reg  [1:0]  O_FRAC_DIGITS,   // nmea fractional digit count
   output reg  [2:0]  O_UTC_VARIANT,   // utc variant setting, copied; not applied to utc outputs
   output reg         O_DATE_KNOWN_FLAG,          // date known
   output reg         O_TIME_KNOWN_FLAG,          // time known
   output reg         O_DATE_VERIFIED_FLAG,       // date verified
   output reg         O_TIME_VERIFIED_FLAG,       // time verified
   output reg         O_VERIFICATION_AVAILABLE_BIT, // verification available
   output reg         O_WHOLE_SECOND_RESOLVED_FLAG  // utc second unambiguous
);
   localparam ST_IDLE = 2'b00;
   localparam ST_CONV = 2'b01;
   localparam ST_DATE = 2'b10;
   localparam ST_OUT  = 2'b11;

   reg [17:0] div_r;
   reg        tick_r;
   reg [15:0] epoch_cnt_r;
   reg [15:0] period_r;
   reg [31:0] local_ms_r;
   reg [31:0] bias_r;
   reg [31:0] ep_local_r;
   reg        leap_ok_r;
   reg [7:0]  leap_r;
   reg        s1_r, s2_r, s3_r;
   reg [1:0]  st_r;
   reg [31:0] gps_ms_r;
   reg [19:0] sub_ns_r;
   reg [31:0] utc_ms_r;
   reg [15:0] week_r;
   reg        glo_r;
   reg        grp_r;
   reg        date_start_r;
   reg [6:0]  hund_r;
   reg [31:0] nano_r;
   reg [31:0] sod_s_r;
   reg [31:0] nano_nxt;
   reg [6:0]  hund_nxt;
   reg [31:0] sec_nxt;
   reg [19:0] day_nxt;
   reg [19:0] day_r;
   reg [31:0] hund_full;
   reg [31:0] day_full;
   wire       date_done;
   wire [11:0] d_year;
   wire [3:0]  d_month;
   wire [4:0]  d_day;
   // wide quotients, cut to field width on purpose where they are published
   wire [31:0] hour_full = sod_s_r / 32'd3600;
   wire [31:0] min_full  = (sod_s_r / 32'd60) % 32'd60;
   wire [31:0] sec_full  = sod_s_r % 32'd60;

   // 1 khz reference tick from the oscillator clock
   always @(posedge I_MCLK or negedge I_RESETN)
   begin
      if (!I_RESETN)
      begin
         div_r      <= 18'h00000;
         tick_r     <= 1'b0;
         local_ms_r <= 32'h00000000;
      end
      else
      begin
         tick_r <= 1'b0;
         if (div_r == (`NETF_TICK_DIV - 1))
         begin
            div_r      <= 18'h00000;
            tick_r     <= 1'b1;
            local_ms_r <= local_ms_r + 32'h00000001;
         end
         else
            div_r <= div_r + 18'h00001;
      end
   end

   // the solution pulse is an async strobe; two flops, then a third for the edge
   // so that no logic ever reads the possibly metastable first stage
   always @(posedge I_MCLK or negedge I_RESETN)
   begin
      if (!I_RESETN)
      begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
      end
      else
      begin
         s1_r <= I_SOLN_VALID;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // epoch scheduler: nominal 1000 ticks, trimmed by the bias sign
   always @(posedge I_MCLK or negedge I_RESETN)
   begin
      if (!I_RESETN)
      begin
         epoch_cnt_r <= 16'h0000;
         period_r    <= `NETF_EPOCH_NOM;
         O_EPOCH     <= 1'b0;
         ep_local_r  <= 32'h00000000;
      end
      else
      begin
         O_EPOCH <= 1'b0;
         if (tick_r)
         begin
            if (epoch_cnt_r >= period_r - 16'h0001)
            begin
               epoch_cnt_r <= 16'h0000;
               O_EPOCH     <= 1'b1;
               ep_local_r  <= local_ms_r;
               // nearest tick: local late means shorten, early means lengthen
               if ($signed(bias_r) > 0)
                  period_r <= `NETF_EPOCH_SHORT;
               else if ($signed(bias_r) < 0)
                  period_r <= `NETF_EPOCH_LONG;
               else
                  period_r <= `NETF_EPOCH_NOM;
            end
            else
               epoch_cnt_r <= epoch_cnt_r + 16'h0001;
         end
      end
   end

   // conversion parameters: aiding wins when both arrive together
   always @(posedge I_MCLK or negedge I_RESETN)
   begin
      if (!I_RESETN)
      begin
         leap_ok_r <= 1'b0;
         leap_r    <= `NETF_DEF_LEAP_S;
      end
      else if (I_AID_VALID)
      begin
         leap_ok_r <= 1'b1;
         leap_r    <= I_AID_LEAP;
      end
      else if (I_BCAST_VALID)
      begin
         leap_ok_r <= 1'b1;
         leap_r    <= I_BCAST_LEAP;
      end
   end

   // utc rounding to hundredths; carry into seconds gives negative nano
   always @*
   begin
      sec_nxt  = utc_ms_r / 32'd1000;
      nano_nxt = (utc_ms_r % 32'd1000) * `NETF_NS_PER_MS + {12'h000, sub_ns_r};
      hund_nxt = 7'h00;
      hund_full = 32'h00000000;
      if (nano_nxt >= 32'd995000000)
      begin
         sec_nxt  = sec_nxt + 32'd1;
         nano_nxt = nano_nxt - 32'd1000000000;
      end
      else
      begin
         // nano keeps the whole sub-second part: it corrects the rounded second
         hund_full = (nano_nxt + `NETF_ROUND_HALF_NS) / `NETF_ROUND_STEP_NS;
         hund_nxt  = hund_full[6:0];
      end
      day_full = ({16'h0, week_r} * 32'd7) + (sec_nxt / 32'd86400);
      day_nxt  = day_full[19:0];
   end

   // epoch pipeline: latch once, convert, format, publish together
   always @(posedge I_MCLK or negedge I_RESETN)
   begin
      if (!I_RESETN)
      begin
         st_r <= ST_IDLE;
         gps_ms_r <= 32'h0;
         sub_ns_r <= 20'h0;
         utc_ms_r <= 32'h0;
         week_r <= `NETF_BASE_WEEK_RST;
         glo_r <= 1'b0;
         grp_r <= 1'b0;
         bias_r <= 32'h0;
         date_start_r <= 1'b0;
         hund_r <= 7'h0;
         nano_r <= 32'h0;
         sod_s_r <= 32'h0;
         day_r <= 20'h0;
         O_REPORT <= 1'b0;
         O_EPOCH_WEEK_TIME_STAMP <= 32'h0;
         O_WEEK <= 16'h0;
         O_GROUP <= 1'b0;
         O_LOCAL_MS <= 32'h0;
         O_CLOCK_BIAS <= 32'h0;
         O_CLOCK_DRIFT <= 32'h0;
         O_YEAR <= 12'h0;
         O_MONTH <= 4'h0;
         O_DAY <= 5'h0;
         O_HOUR <= 5'h0;
         O_MIN <= 6'h0;
         O_SEC <= 6'h0;
         O_NANO <= 32'h0;
         O_HUNDREDTHS <= 7'h0;
         O_FRAC_DIGITS <= 2'h2;
         O_UTC_VARIANT <= 3'h0;
         O_DATE_KNOWN_FLAG <= 1'b0;
         O_TIME_KNOWN_FLAG <= 1'b0;
         O_DATE_VERIFIED_FLAG <= 1'b0;
         O_TIME_VERIFIED_FLAG <= 1'b0;
         O_VERIFICATION_AVAILABLE_BIT <= 1'b0;
         O_WHOLE_SECOND_RESOLVED_FLAG <= 1'b0;
      end
      else
      begin
         O_REPORT     <= 1'b0;
         date_start_r <= 1'b0;
         case (st_r)
            ST_IDLE:
            begin
               if (s3_r && !s2_r)
               begin
                  // bias = solved minus tick-based local time
                  bias_r   <= I_SOLN_TOW_MS - ep_local_r;
                  gps_ms_r <= I_SOLN_TOW_MS;
                  sub_ns_r <= I_SOLN_NS;
                  week_r   <= I_WEEK;
                  glo_r    <= I_SOLN_IS_GLO;
                  grp_r    <= I_PRIO_GROUP;
                  st_r     <= ST_CONV;
               end
            end
            ST_CONV:
            begin
               // gps base: glonass needs the inter-system offset, else default
               if (glo_r)
                  gps_ms_r <= gps_ms_r + 32'd1000 *
                              {24'h0, I_GLO_OFS_OK ? I_GLO_OFS : `NETF_DEF_GLO_OFS_S};
               // utc base: gps time less the leap count, known or the fixed default; glonass time as solved
               utc_ms_r <= glo_r ? gps_ms_r : gps_ms_r - 32'd1000 * {24'h0, leap_r};
               st_r <= ST_DATE;
            end
            ST_DATE:
            begin
               sod_s_r <= sec_nxt % 32'd86400;
               day_r   <= day_nxt;
               hund_r  <= hund_nxt;
               nano_r  <= nano_nxt;
               date_start_r <= 1'b1;
               st_r <= ST_OUT;
            end
            ST_OUT:
            begin
               if (date_done)
               begin
                  st_r <= ST_IDLE;
                  // invalid times only leave when configured to
                  if (I_OUT_INVALID || (I_WEEK_OK && leap_ok_r))
                  begin
                     O_REPORT <= 1'b1;
                     O_EPOCH_WEEK_TIME_STAMP <= gps_ms_r % `NETF_MS_PER_WEEK;
                     O_WEEK <= week_r;
                     O_GROUP <= I_PRIO_MODE & grp_r;
                     O_LOCAL_MS <= ep_local_r;
                     O_CLOCK_DRIFT <= bias_r - O_CLOCK_BIAS;
                     O_CLOCK_BIAS <= bias_r;
                     O_YEAR <= d_year;
                     O_MONTH <= d_month;
                     O_DAY <= d_day;
                     O_HOUR <= hour_full[4:0];
                     O_MIN <= min_full[5:0];
                     O_SEC <= sec_full[5:0];
                     O_NANO <= nano_r;
                     O_HUNDREDTHS <= hund_r;
                     O_FRAC_DIGITS <= I_NMEA_LEGACY ? 2'h3 : 2'h2;
                     O_UTC_VARIANT <= I_UTC_VARIANT;
                     O_DATE_KNOWN_FLAG <= I_WEEK_OK;
                     O_TIME_KNOWN_FLAG <= 1'b1;
                     O_VERIFICATION_AVAILABLE_BIT <= I_CHECK_AVAIL;
                     O_DATE_VERIFIED_FLAG <= I_CHECK_AVAIL & I_DATE_CHECK & I_WEEK_OK;
                     O_TIME_VERIFIED_FLAG <= I_CHECK_AVAIL & I_TIME_CHECK;
                     O_WHOLE_SECOND_RESOLVED_FLAG <= glo_r | leap_ok_r;
                  end
               end
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end

   netf_date_conv u_date
   (
      .i_clk   (I_MCLK),
      .i_rst_n (I_RESETN),
      .i_start (date_start_r),
      .i_days  (day_r),
      .o_done  (date_done),
      .o_year  (d_year),
      .o_month (d_month),
      .o_day   (d_day)
   );
endmodule

// file: dv/netf_host_model.sv
// host-side model that takes in each epoch report as it stands
module netf_host_model
(
   input  wire logic        i_clk,   // system clock
   input  wire logic        i_rst_n, // asynchronous reset, active low
   input  wire logic        i_report, // report strobe
   input  wire logic [31:0] i_stamp, // epoch time stamp
   output logic      [15:0] o_count, // reports taken
   output logic      [31:0] o_stamp  // stamp of the last report
);
   timeunit 1ns;
   timeprecision 1ps;
   // a report is only looked at in its one strobe cycle, like a real host
   always @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_count <= 16'h0000;
         o_stamp <= 32'h0000_0000;
      end
      else if (i_report)
      begin
         o_count <= o_count + 16'h0001;
         o_stamp <= i_stamp;
      end
   end
endmodule

// file: dv/netf_top_sva.sv
// checker for the report outputs of the time formatter
module netf_top_sva
(
   input wire logic        I_MCLK,       // clock
   input wire logic        I_RESETN,     // reset, active low
   input wire logic        I_NMEA_LEGACY, // legacy format
   input wire logic        I_WEEK_OK,    // week known
   input wire logic        O_EPOCH,      // epoch pulse
   input wire logic        O_REPORT,     // report pulse
   input wire logic [31:0] O_EPOCH_WEEK_TIME_STAMP, // stamp
   input wire logic [4:0]  O_HOUR,       // hour
   input wire logic [5:0]  O_MIN,        // minute
   input wire logic [5:0]  O_SEC,        // second
   input wire logic [31:0] O_NANO,       // ns correction
   input wire logic [6:0]  O_HUNDREDTHS, // hundredths
   input wire logic [1:0]  O_FRAC_DIGITS, // digits
   input wire logic        O_DATE_KNOWN_FLAG, // date known
   input wire logic        O_DATE_VERIFIED_FLAG, // date verified
   input wire logic        O_TIME_VERIFIED_FLAG, // time verified
   input wire logic        O_VERIFICATION_AVAILABLE_BIT, // verify avail
   input wire logic        O_WHOLE_SECOND_RESOLVED_FLAG // resolved
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (!I_RESETN);
   // pulses last one cycle so a host never counts one epoch twice
   AST_REPORT_PULSE: assert property (O_REPORT |=> !O_REPORT)
      else $error("report strobe longer than one cycle");
   AST_EPOCH_PULSE: assert property (O_EPOCH |=> !O_EPOCH)
      else $error("epoch strobe longer than one cycle");
   // one latched value per epoch: nothing moves between strobes
   AST_STAMP_HOLD: assert property (!O_REPORT |-> $stable(O_EPOCH_WEEK_TIME_STAMP))
      else $error("stamp moved without a report");
   AST_UTC_HOLD: assert property (!O_REPORT |-> $stable({O_HOUR, O_MIN, O_SEC, O_NANO}))
      else $error("utc fields moved without a report");
   AST_NANO_RANGE: assert property (O_REPORT |-> $signed(O_NANO) >= -32'sd5000000
      && $signed(O_NANO) <= 32'sd994999999)
      else $error("ns correction out of range");
   AST_CARRY_ZERO: assert property (O_REPORT && O_NANO[31] |-> O_HUNDREDTHS == 7'h00)
      else $error("negative correction without round-up");
   AST_HUNDREDTHS: assert property (O_REPORT && !O_NANO[31]
      |-> O_HUNDREDTHS == (O_NANO + 32'd5000000) / 32'd10000000)
      else $error("hundredths not rounded from ns");
   AST_FRAC_DIGITS: assert property (O_REPORT
      |-> O_FRAC_DIGITS == (I_NMEA_LEGACY ? 2'h3 : 2'h2))
      else $error("wrong fractional digit count");
   AST_VERIFY_GATE: assert property (O_REPORT && !O_VERIFICATION_AVAILABLE_BIT
      |-> !O_DATE_VERIFIED_FLAG && !O_TIME_VERIFIED_FLAG)
      else $error("verified flag without availability");
   AST_DATE_GATE: assert property (O_REPORT && !I_WEEK_OK |-> !O_DATE_KNOWN_FLAG)
      else $error("date known without week");
   AST_TIME_RANGE: assert property (O_REPORT |-> O_HOUR < 5'h18 && O_MIN < 6'h3c)
      else $error("hour or minute out of range");
   COV_CARRY: cover property (O_REPORT && O_NANO[31]);
   COV_LEGACY: cover property (O_REPORT && O_FRAC_DIGITS == 2'h3);
   COV_RESOLVED: cover property (O_REPORT && O_WHOLE_SECOND_RESOLVED_FLAG);
endmodule
bind netf_top netf_top_sva chk_u (.I_MCLK(I_MCLK), .I_RESETN(I_RESETN),
   .I_NMEA_LEGACY(I_NMEA_LEGACY), .I_WEEK_OK(I_WEEK_OK), .O_EPOCH(O_EPOCH),
   .O_REPORT(O_REPORT), .O_EPOCH_WEEK_TIME_STAMP(O_EPOCH_WEEK_TIME_STAMP),
   .O_HOUR(O_HOUR), .O_MIN(O_MIN), .O_SEC(O_SEC), .O_NANO(O_NANO),
   .O_HUNDREDTHS(O_HUNDREDTHS), .O_FRAC_DIGITS(O_FRAC_DIGITS),
   .O_DATE_KNOWN_FLAG(O_DATE_KNOWN_FLAG), .O_DATE_VERIFIED_FLAG(O_DATE_VERIFIED_FLAG),
   .O_TIME_VERIFIED_FLAG(O_TIME_VERIFIED_FLAG),
   .O_VERIFICATION_AVAILABLE_BIT(O_VERIFICATION_AVAILABLE_BIT),
   .O_WHOLE_SECOND_RESOLVED_FLAG(O_WHOLE_SECOND_RESOLVED_FLAG));

// file: dv/test_nav_epoch_time_formatter.sv
// self-checking bench for the navigation epoch time formatter
module test_nav_epoch_time_formatter;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, sv, glo, bv, av, gok, wok, dchk, tchk, cav, oinv, pm, pg, leg;
   logic [31:0] tow;
   logic [19:0] sns;
   logic [7:0] bl, al, go;
   logic [15:0] wk, cnt;
   logic [2:0] var_sel, o_var;
   logic [31:0] stamp, h_stamp, lms, bias, drift, nano;
   logic [15:0] o_wk;
   logic [11:0] yr;
   logic [3:0] mo;
   logic [4:0] dy, hr;
   logic [5:0] mi, se;
   logic [6:0] hu;
   logic [1:0] fd;
   logic ep, rep, grp, dk, tk, dv, tv, va, res;
   int errors = 0;
   int n_compared = 0;
   netf_top dut_u (.I_MCLK(clk), .I_RESETN(rst_n), .I_SOLN_VALID(sv), .I_SOLN_TOW_MS(tow),
      .I_SOLN_NS(sns), .I_SOLN_IS_GLO(glo), .I_BCAST_VALID(bv), .I_BCAST_LEAP(bl),
      .I_AID_VALID(av), .I_AID_LEAP(al), .I_GLO_OFS(go), .I_GLO_OFS_OK(gok),
      .I_WEEK_OK(wok), .I_WEEK(wk), .I_DATE_CHECK(dchk), .I_TIME_CHECK(tchk),
      .I_CHECK_AVAIL(cav), .I_OUT_INVALID(oinv), .I_PRIO_MODE(pm), .I_PRIO_GROUP(pg),
      .I_NMEA_LEGACY(leg), .I_UTC_VARIANT(var_sel), .O_EPOCH(ep), .O_REPORT(rep),
      .O_EPOCH_WEEK_TIME_STAMP(stamp), .O_WEEK(o_wk), .O_GROUP(grp), .O_LOCAL_MS(lms),
      .O_CLOCK_BIAS(bias), .O_CLOCK_DRIFT(drift), .O_YEAR(yr), .O_MONTH(mo), .O_DAY(dy),
      .O_HOUR(hr), .O_MIN(mi), .O_SEC(se), .O_NANO(nano), .O_HUNDREDTHS(hu),
      .O_FRAC_DIGITS(fd), .O_UTC_VARIANT(o_var), .O_DATE_KNOWN_FLAG(dk),
      .O_TIME_KNOWN_FLAG(tk), .O_DATE_VERIFIED_FLAG(dv), .O_TIME_VERIFIED_FLAG(tv),
      .O_VERIFICATION_AVAILABLE_BIT(va), .O_WHOLE_SECOND_RESOLVED_FLAG(res));
   netf_host_model host_u (.i_clk(clk), .i_rst_n(rst_n), .i_report(rep), .i_stamp(stamp),
      .o_count(cnt), .o_stamp(h_stamp));
   // 200 mhz clock
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task report_and_stop;
      $display("compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task chk_v(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task chk_f(input string nm, input logic e, input logic g);
      chk_v(nm, {31'h0, e}, {31'h0, g});
   endtask
   // one solution: valid high three cycles, data held well past the fall
   task sol(input logic [31:0] t, input logic [19:0] n, input logic g, input logic want);
      logic [15:0] c0;
      c0 = cnt;
      @(negedge clk);
      {tow, sns, glo, sv} = {t, n, g, 1'b1};
      repeat (3) @(negedge clk);
      sv = 1'b0;
      for (int i = 0; i < 1000 && cnt == c0; i++) @(negedge clk);
      chk_f("report", want, cnt != c0);
      repeat (600) @(negedge clk);
   endtask
   // expected utc from gps time of week and leap count, rounded to 10 ms
   task chk_utc(input longint t, input longint n, input longint lp);
      longint ms, sub, s;
      ms = (t - lp * 1000) % 86400000;
      sub = (ms % 1000) * 1000000 + n;
      s = ms / 1000;
      chk_v("stamp", t[31:0], h_stamp);
      // no epoch falls inside this short run, so local time at the epoch is still zero
      chk_v("bias", t[31:0], bias);
      chk_v("local_ms", 32'h0, lms);
      if (sub >= 995000000)
      begin
         s = (s + 1) % 86400;
         sub = sub - 1000000000;
         chk_v("hund", 32'h0, {25'h0, hu});
      end
      else
         chk_v("hund", (sub + 5000000) / 10000000, {25'h0, hu});
      chk_v("nano", sub[31:0], nano);
      chk_v("hms", {15'h0, 5'(s / 3600), 6'((s / 60) % 60), 6'(s % 60)},
         {15'h0, hr, mi, se});
   endtask
   // defaults: no leap data, no week, invalid output first refused then shown
   task t_defaults;
      sol(32'd200000000, 20'h0, 1'b0, 1'b0);
      oinv = 1'b1;
      sol(32'd200000000, 20'h0, 1'b0, 1'b1);
      chk_utc(200000000, 0, 18);
      chk_f("resolved", 1'b0, res);
      chk_f("date_known", 1'b0, dk);
      chk_f("time_known", 1'b1, tk);
      sol(32'd200000000, 20'h0, 1'b1, 1'b1);
      chk_f("resolved_glo", 1'b1, res);
      $display("test defaults done");
   endtask
   // leap count from broadcast, then from the aiding message
   task t_leap;
      @(negedge clk);
      {bv, bl} = {1'b1, 8'h07};
      @(negedge clk);
      bv = 1'b0;
      wok = 1'b1;
      sol(32'd300000000, 20'h0, 1'b0, 1'b1);
      chk_utc(300000000, 0, 7);
      chk_f("resolved", 1'b1, res);
      chk_f("date_known", 1'b1, dk);
      chk_v("week", 32'h800, {16'h0, o_wk});
      // day 14339 from the base year start, four-year leap rule: year 2019, month 4, day 5
      chk_v("date", {11'h0, 12'd2019, 4'd4, 5'd5}, {11'h0, yr, mo, dy});
      {av, al} = {1'b1, 8'h05};
      @(negedge clk);
      av = 1'b0;
      sol(32'd300000000, 20'h0, 1'b0, 1'b1);
      chk_utc(300000000, 0, 5);
      $display("test leap done");
   endtask
   // rounding: plain hundredths, just below the carry, and the full carry
   task t_round;
      sol(32'd45005521, 20'd4999, 1'b0, 1'b1);
      chk_utc(45005521, 4999, 5);
      sol(32'd45005994, 20'd999999, 1'b0, 1'b1);
      chk_utc(45005994, 999999, 5);
      chk_v("drift", 32'd473, drift);
      sol(32'd172804999, 20'd300000, 1'b0, 1'b1);
      chk_utc(172804999, 300000, 5);
      // the round-up crosses midnight: day 14338, one day on from the unrounded date
      chk_v("date_carry", {11'h0, 12'd2019, 4'd4, 5'd4}, {11'h0, yr, mo, dy});
      $display("test round done");
   endtask
   // flag, format, variant and group settings
   task t_flags;
      for (int i = 0; i < 8; i++)
      begin
         {cav, dchk, tchk} = i[2:0];
         leg = i[0];
         var_sel = i[2:0];
         {pm, pg} = i[1:0];
         sol(32'd1000 * i + 32'd7000, 20'h0, 1'b0, 1'b1);
         chk_f("avail", i[2], va);
         chk_f("date_ver", i[2] & i[1], dv);
         chk_f("time_ver", i[2] & i[0], tv);
         chk_v("digits", i[0] ? 32'h3 : 32'h2, {30'h0, fd});
         chk_v("variant", i, {29'h0, o_var});
         chk_f("group", i[1] & i[0], grp);
      end
      $display("test flags done");
   endtask
   // a hang counts as a mismatch
   initial
   begin
      #400000;
      errors++;
      report_and_stop;
   end
   initial
   begin
      {sv, glo, bv, av, gok, wok, dchk, tchk, cav, oinv, pm, pg, leg} = 13'h0;
      {tow, sns, bl, al, go, var_sel} = 0;
      wk = 16'h0800;
      rst_n = 1'b0;
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      chk_v("digits_rst", 32'h2, {30'h0, fd});
      t_defaults;
      t_leap;
      t_round;
      t_flags;
      report_and_stop;
   end
endmodule
